// ==== uart_irq_enable_regs.vh ====
// Register map, bit positions, codes and reset values of the UART interrupt enable block.
// Assumes an 8-bit register port with a 3-bit address, driven from the core_clk domain.
`ifndef UART_IRQ_ENABLE_REGS_VH
`define UART_IRQ_ENABLE_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_TX_HOLDING      3'h0
`define ADDR_INT_ENABLE      3'h1
`define ADDR_INT_STATUS      3'h2
`define ADDR_FIFO_CONTROL    3'h3
`define ADDR_EVENT_STATUS    3'h4
`define ADDR_LINE_STATUS     3'h5
`define ADDR_MODEM_STATUS    3'h6

// ****************************************
// Interrupt enable bit positions
// ****************************************
`define IE_RX_READY          0
`define IE_TX_READY          1
`define IE_LINE_STATUS       2
`define IE_MODEM_STATUS      3
`define IE_SLEEP             4
`define IE_XOFF              5
`define IE_RTS               6
`define IE_CTS               7

// ****************************************
// Other field positions
// ****************************************
`define FC_FIFO_EN           0
`define LS_DATA_READY        0
`define LS_ERR_LO            1
`define LS_TX_EMPTY          5
`define LS_TX_IDLE           6
`define LS_FIFO_ERR          7

// ****************************************
// Interrupt status codes, highest priority first
// ****************************************
`define INT_CODE_LINE        8'h06
`define INT_CODE_RX_READY    8'h04
`define INT_CODE_TX_READY    8'h02
`define INT_CODE_MODEM       8'h00
`define INT_CODE_XOFF        8'h10
`define INT_CODE_CTS_RTS     8'h20
`define INT_CODE_NONE        8'h01

// ****************************************
// Reset values and constants
// ****************************************
`define RST_BYTE             8'h00
`define RST_NIBBLE           4'h0
`define ZERO_LEVEL           8'h00
`define SLEEP_CLEAR_MASK     8'hef

`endif

// ==== uart_irq_enable.v ====
// Interrupt enable, masking and priority logic of a single-channel UART with FIFOs.
// Assumes the FIFOs, serial engines and modem block sit on core_clk beside it;
// only the clear-to-send pin arrives from outside and is synchronised here.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "uart_irq_enable_regs.vh"

module uart_irq_enable (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Receive side status
  input  wire [7:0] rx_fifo_level,
  input  wire [7:0] rx_trigger_level,
  input  wire       rx_char_push,
  input  wire [3:0] rx_err_flags,
  input  wire       rx_fifo_err_any,
  input  wire       xoff_received,
  // Transmit side status
  input  wire       tx_fifo_empty,
  input  wire       tx_shift_empty,
  // Modem lines
  input  wire       cts_pin,
  input  wire       rts_level,
  input  wire [3:0] modem_lines,
  input  wire [3:0] modem_change_evt,
  // Outputs to the UART core and host
  output reg        tx_load,
  output reg  [7:0] tx_load_data,
  output reg        fifo_enable,
  output reg        sleep_enable,
  output reg        irq
);

  // ****************************************
  // State
  // ****************************************
  reg  [7:0] interrupt_enable_reg;
  reg        data_ready;
  reg        tx_flag;
  reg        tx_empty_prev;
  reg        xoff_sticky;
  reg        cts_sticky;
  reg        rts_sticky;
  reg  [3:0] modem_delta;
  reg        cts_s1;
  reg        cts_s2;
  reg        cts_s3;
  reg        cts_level;
  reg        rts_prev;

  // ****************************************
  // Decodes
  // ****************************************
  wire wr_enable       = reg_wr && (reg_addr == `ADDR_INT_ENABLE);
  wire wr_fifo_ctl     = reg_wr && (reg_addr == `ADDR_FIFO_CONTROL);
  wire wr_tx_hold      = reg_wr && (reg_addr == `ADDR_TX_HOLDING);
  wire wr_evt          = reg_wr && (reg_addr == `ADDR_EVENT_STATUS);
  wire rd_int_status   = reg_rd && (reg_addr == `ADDR_INT_STATUS);
  wire rd_modem_status = reg_rd && (reg_addr == `ADDR_MODEM_STATUS);

  // ****************************************
  // Source conditions
  // ****************************************
  // Filtered CTS only moves once the last two stages agree, so glitches are dropped
  wire cts_stable = (cts_s2 == cts_s3);
  wire cts_rise   = cts_stable && cts_s3 && !cts_level;
  wire rts_rise   = rts_level && !rts_prev;
  wire rx_not_empty = (rx_fifo_level != `ZERO_LEVEL);
  wire rx_cond    = fifo_enable ? (rx_fifo_level >= rx_trigger_level)
                                : rx_not_empty;
  wire line_cond  = |rx_err_flags;
  wire modem_cond = |modem_delta;
  wire tx_drain   = tx_fifo_empty && !tx_empty_prev;
  wire tx_cond    = fifo_enable ? tx_flag : tx_fifo_empty;
  wire polled     = fifo_enable &&
                    (interrupt_enable_reg[`IE_MODEM_STATUS:`IE_RX_READY] == `RST_NIBBLE);

  wire [7:0] pending = {cts_sticky, rts_sticky, xoff_sticky, 1'b0,
                        modem_cond, line_cond, tx_cond, rx_cond};
  // Sleep enable is not a source and is kept out of the gate
  wire [7:0] active  = pending & interrupt_enable_reg & `SLEEP_CLEAR_MASK;
  wire       next_irq = (|active) && !polled;

  // ****************************************
  // Priority encoder
  // ****************************************
  reg [7:0] int_code;
  always @* begin
    int_code = `INT_CODE_NONE;
    if (polled) begin
      int_code = `INT_CODE_NONE;
    end else if (active[`IE_LINE_STATUS]) begin
      int_code = `INT_CODE_LINE;
    end else if (active[`IE_RX_READY]) begin
      int_code = `INT_CODE_RX_READY;
    end else if (active[`IE_TX_READY]) begin
      int_code = `INT_CODE_TX_READY;
    end else if (active[`IE_MODEM_STATUS]) begin
      int_code = `INT_CODE_MODEM;
    end else if (active[`IE_XOFF]) begin
      int_code = `INT_CODE_XOFF;
    end else if (active[`IE_CTS] || active[`IE_RTS]) begin
      int_code = `INT_CODE_CTS_RTS;
    end
  end

  wire [7:0] line_status = {fifo_enable && rx_fifo_err_any,
                            tx_fifo_empty && tx_shift_empty,
                            tx_fifo_empty,
                            rx_err_flags,
                            data_ready};

  // ****************************************
  // Read mux
  // ****************************************
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_INT_ENABLE:   next_rdata = interrupt_enable_reg;
        `ADDR_INT_STATUS:   next_rdata = {fifo_enable, fifo_enable, int_code[5:0]};
        `ADDR_FIFO_CONTROL: next_rdata = {7'h00, fifo_enable};
        `ADDR_EVENT_STATUS: next_rdata = pending;
        `ADDR_LINE_STATUS:  next_rdata = line_status;
        `ADDR_MODEM_STATUS: next_rdata = {modem_lines, modem_delta};
        default:            next_rdata = `RST_BYTE;
      endcase
    end
  end

  // ****************************************
  // Modem change flags, one per bit
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_delta
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          modem_delta[gi] <= 1'b0;
        end else begin
          // A change arriving with the read still lands
          modem_delta[gi] <= modem_change_evt[gi] ||
                             (modem_delta[gi] && !rd_modem_status);
        end
      end
    end
  endgenerate

  // ****************************************
  // Next values of the sticky flags
  // ****************************************
  // Set wins over every clear, so an event in the clearing cycle is never lost
  // Status read, holding load or a written one all clear the transmit flag
  wire clr_tx           = rd_int_status || wr_tx_hold || (wr_evt && reg_wdata[`IE_TX_READY]);
  wire clr_xoff         = wr_evt && reg_wdata[`IE_XOFF];
  wire clr_rts          = wr_evt && reg_wdata[`IE_RTS];
  wire clr_cts          = wr_evt && reg_wdata[`IE_CTS];
  wire next_tx_flag     = tx_drain || (tx_flag && !clr_tx);
  wire next_xoff_sticky = xoff_received || (xoff_sticky && !clr_xoff);
  wire next_rts_sticky  = rts_rise || (rts_sticky && !clr_rts);
  wire next_cts_sticky  = cts_rise || (cts_sticky && !clr_cts);
  // Push wins over the empty clear
  wire next_data_ready  = rx_char_push || (data_ready && rx_not_empty);
  wire next_sleep       = wr_enable ? reg_wdata[`IE_SLEEP]
                                    : interrupt_enable_reg[`IE_SLEEP];

  // ****************************************
  // Host registers
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_reg <= `RST_BYTE;
    end else begin
      if (wr_enable) begin
        interrupt_enable_reg <= reg_wdata;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_enable <= 1'b0;
    end else begin
      if (wr_fifo_ctl) begin
        fifo_enable <= reg_wdata[`FC_FIFO_EN];
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_enable <= 1'b0;
    end else begin
      sleep_enable <= next_sleep;
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  // Registered so the pin never glitches while the sources settle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ****************************************
  // Read data and transmit load
  // ****************************************
  // Read data stands one cycle only, then returns to zero
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RST_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_load <= 1'b0;
    end else begin
      tx_load <= wr_tx_hold;
    end
  end

  // The data is held, so the core may take it a little later than the pulse
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_load_data <= `RST_BYTE;
    end else begin
      if (wr_tx_hold) begin
        tx_load_data <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Receive and transmit flags
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= next_data_ready;
    end
  end

  // Resets to the idle level of an empty FIFO, so no false drain follows reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_empty_prev <= 1'b1;
    end else begin
      tx_empty_prev <= tx_fifo_empty;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_flag <= 1'b0;
    end else begin
      tx_flag <= next_tx_flag;
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xoff_sticky <= 1'b0;
    end else begin
      xoff_sticky <= next_xoff_sticky;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_sticky <= 1'b0;
    end else begin
      rts_sticky <= next_rts_sticky;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_sticky <= 1'b0;
    end else begin
      cts_sticky <= next_cts_sticky;
    end
  end

  // ****************************************
  // Clear-to-send synchroniser
  // ****************************************
  // The pin is asynchronous; the first stage may go metastable and is read
  // by the second stage only. The cost is four to five cycles of latency.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_s1 <= 1'b0;
    end else begin
      cts_s1 <= cts_pin;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_s2 <= 1'b0;
    end else begin
      cts_s2 <= cts_s1;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_s3 <= 1'b0;
    end else begin
      cts_s3 <= cts_s2;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_level <= 1'b0;
    end else begin
      if (cts_stable) begin
        cts_level <= cts_s3;
      end
    end
  end

  // ****************************************
  // Request-to-send edge
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_prev <= 1'b0;
    end else begin
      rts_prev <= rts_level;
    end
  end

endmodule

// ==== uart_irq_enable_chk.sv ====
// Assertions on the ports of the UART interrupt enable block.
// Assumes one clock, active low reset and the offsets of the shared header.
`timescale 1ns/1ps
`include "uart_irq_enable_regs.vh"
module uart_irq_enable_chk (
  // Clock and reset
  input logic       core_clk,
  input logic       rst_b,
  // Register port
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  // Sources
  input logic [7:0] rx_fifo_level,
  input logic [7:0] rx_trigger_level,
  input logic       xoff_received,
  input logic       tx_fifo_empty,
  input logic       cts_pin,
  // Outputs
  input logic       fifo_enable,
  input logic       sleep_enable,
  input logic       irq
);
  // Enable register rebuilt from bus writes, since it has no port of its own
  logic [7:0] enable_shadow;
  logic       polled;
  assign polled = fifo_enable && (enable_shadow[3:0] == 4'h0);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_shadow <= 8'h00;
    end else if (reg_wr && reg_addr == `ADDR_INT_ENABLE) begin
      enable_shadow <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Synchroniser delay is 4 to 5 cycles, so a small window is allowed
  sequence cts_rise;
    $rose(cts_pin) && enable_shadow[7] && !polled;
  endsequence
  AST_CTS_IRQ: assert property (cts_rise |-> ##[3:6] irq)
    else $error("clear-to-send edge gave no interrupt");
  AST_XOFF_IRQ: assert property (xoff_received && enable_shadow[5] && !polled && !reg_wr
    |-> ##2 irq)
    else $error("xoff gave no interrupt");
  AST_SLEEP_BIT: assert property (sleep_enable == enable_shadow[4])
    else $error("sleep output differs from enable bit");
  AST_TX_IRQ: assert property (!fifo_enable && enable_shadow[1] && tx_fifo_empty |=> irq)
    else $error("transmit empty gave no interrupt");
  AST_RX_IRQ: assert property (enable_shadow[0] && (fifo_enable ? rx_fifo_level >= rx_trigger_level
    : rx_fifo_level != 8'h00) |=> irq)
    else $error("receive ready gave no interrupt");
  AST_ENABLE_READ: assert property (reg_rd && reg_addr == `ADDR_INT_ENABLE
    |=> reg_rdata == $past(enable_shadow))
    else $error("enable register read back wrong");
  AST_POLLED: assert property (polled |=> !irq)
    else $error("interrupt in polled mode");
  AST_FIFO_BIT: assert property (reg_wr && reg_addr == `ADDR_FIFO_CONTROL |=> fifo_enable == $past(reg_wdata[0]))
    else $error("fifo enable not taken from write");
endmodule

// ==== host_bus.sv ====
// Host processor model: drives the register port of the interrupt block.
// Assumes core_clk; strobes are one cycle long and the slave never waits.
`timescale 1ns/1ps
module host_bus (
  input  logic       core_clk,
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 13'h0;
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Status and line reads are the host's polling and acknowledge path
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// ==== uart_irq_enable_tb.sv ====
// Testbench of the UART interrupt enable block, with host model and checker.
// Assumes the design header and a 250 MHz core_clk.
`timescale 1ns/1ps
`include "uart_irq_enable_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module uart_irq_enable_tb;
  logic       core_clk = 0, rst_b = 0, xoff = 0, txe = 0, tse = 0, cts = 0;
  logic       rts = 0, push = 0, ferr = 0;
  logic [7:0] lvl = 0, trig = 0, rd;
  logic [3:0] mevt = 0, errs = 0;
  wire  [2:0] a;
  wire  [7:0] wd, rdata, tldd;
  wire        wr, rdst, fen, slp, irq, tld;
  int         miscompares = 0, checked = 0, cycles = 0;
  always #2 core_clk = ~core_clk;
  host_bus host_u (.core_clk(core_clk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rdst), .reg_rdata(rdata));
  // Modem levels left quiet
  uart_irq_enable dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rdst), .reg_rdata(rdata), .rx_fifo_level(lvl), .rx_trigger_level(trig),
    .rx_char_push(push), .rx_err_flags(errs), .rx_fifo_err_any(ferr), .xoff_received(xoff),
    .tx_fifo_empty(txe), .tx_shift_empty(tse), .cts_pin(cts), .rts_level(rts),
    .modem_lines(4'h0), .modem_change_evt(mevt), .tx_load(tld), .tx_load_data(tldd),
    .fifo_enable(fen), .sleep_enable(slp), .irq(irq));
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr_ie(input logic [7:0] d);
    host_u.bus_wr(`ADDR_INT_ENABLE, d);
  endtask
  task automatic pulse_xoff;
    @(posedge core_clk) xoff <= 1'b1;
    @(posedge core_clk) xoff <= 1'b0;
    cyc(3);
  endtask
  task automatic t_reset_sleep;
    `CHK({irq, slp, fen}, 3'b000)
    host_u.bus_rd(`ADDR_INT_ENABLE, rd);
    `CHK(rd, 8'h00)
    wr_ie(8'h10);
    cyc(2);
    `CHK({slp, irq}, 2'b10)
  endtask
  task automatic t_xoff;
    wr_ie(8'h20);
    pulse_xoff;
    `CHK(irq, 1'b1)
    host_u.bus_wr(`ADDR_EVENT_STATUS, 8'h20);
    cyc(2);
    `CHK(irq, 1'b0)
    wr_ie(8'h00);
    pulse_xoff;
    `CHK(irq, 1'b0)
    host_u.bus_wr(`ADDR_EVENT_STATUS, 8'h20);
  endtask
  task automatic t_rx;
    wr_ie(8'h01);
    @(posedge core_clk) lvl <= 8'h01;
    cyc(2);
    `CHK(irq, 1'b1)
    host_u.bus_wr(`ADDR_FIFO_CONTROL, 8'h01);
    trig <= 8'h04;
    lvl <= 8'h03;
    cyc(2);
    `CHK({fen, irq}, 2'b10)
    @(posedge core_clk) lvl <= 8'h04;
    cyc(2);
    `CHK(irq, 1'b1)
    host_u.bus_rd(`ADDR_INT_STATUS, rd);
    `CHK(rd, 8'hc4)
  endtask
  task automatic t_polled;
    wr_ie(8'h20);
    txe <= 1'b1;
    pulse_xoff;
    `CHK(irq, 1'b0)
    host_u.bus_rd(`ADDR_LINE_STATUS, rd);
    `CHK(rd[6:5], 2'b01)
    @(posedge core_clk) tse <= 1'b1;
    host_u.bus_rd(`ADDR_LINE_STATUS, rd);
    `CHK(rd[6:5], 2'b11)
    host_u.bus_wr(`ADDR_EVENT_STATUS, 8'h20);
  endtask
  task automatic t_tx_cts_modem;
    host_u.bus_wr(`ADDR_FIFO_CONTROL, 8'h00);
    wr_ie(8'h02);
    cyc(2);
    `CHK(irq, 1'b1)
    @(posedge core_clk) txe <= 1'b0;
    cyc(2);
    `CHK(irq, 1'b0)
    wr_ie(8'h80);
    @(posedge core_clk) cts <= 1'b1;
    cyc(7);
    `CHK(irq, 1'b1)
    wr_ie(8'h08);
    cyc(2);
    `CHK(irq, 1'b0)
    @(posedge core_clk) mevt <= 4'h4;
    @(posedge core_clk) mevt <= 4'h0;
    cyc(3);
    `CHK(irq, 1'b1)
    host_u.bus_rd(`ADDR_MODEM_STATUS, rd);
    `CHK(rd[3:0], 4'h4)
    cyc(2);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_fifo_tx_line;
    host_u.bus_wr(`ADDR_FIFO_CONTROL, 8'h01);
    wr_ie(8'h02);
    host_u.bus_rd(`ADDR_INT_STATUS, rd);
    `CHK(rd, 8'hc2)
    cyc(2);
    `CHK(irq, 1'b0)
    @(posedge core_clk) txe <= 1'b1;
    cyc(3);
    `CHK(irq, 1'b1)
    host_u.bus_wr(`ADDR_TX_HOLDING, 8'h5a);
    #1;
    `CHK({tld, tldd}, 9'h15a)
    cyc(2);
    `CHK({tld, irq}, 2'b00)
    wr_ie(8'h44);
    @(posedge core_clk) rts <= 1'b1;
    cyc(3);
    `CHK(irq, 1'b1)
    host_u.bus_wr(`ADDR_EVENT_STATUS, 8'h40);
    cyc(2);
    `CHK(irq, 1'b0)
    @(posedge core_clk) begin
      errs <= 4'h2;
      ferr <= 1'b1;
    end
    cyc(2);
    `CHK(irq, 1'b1)
    host_u.bus_rd(`ADDR_LINE_STATUS, rd);
    `CHK(rd[4:1], 4'h2)
    `CHK(rd[7], 1'b1)
    @(posedge core_clk) push <= 1'b1;
    @(posedge core_clk) push <= 1'b0;
    host_u.bus_rd(`ADDR_LINE_STATUS, rd);
    `CHK(rd[0], 1'b1)
    @(posedge core_clk) lvl <= 8'h00;
    host_u.bus_rd(`ADDR_LINE_STATUS, rd);
    `CHK(rd[0], 1'b0)
  endtask
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The whole run needs under 150 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(1);
    t_reset_sleep;
    t_xoff;
    t_rx;
    t_polled;
    t_tx_cts_modem;
    t_fifo_tx_line;
    finish_test;
  end
endmodule
bind uart_irq_enable uart_irq_enable_chk chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_fifo_level(rx_fifo_level), .rx_trigger_level(rx_trigger_level),
  .xoff_received(xoff_received), .tx_fifo_empty(tx_fifo_empty), .cts_pin(cts_pin),
  .fifo_enable(fifo_enable), .sleep_enable(sleep_enable), .irq(irq));
